// *** core/pit_top.sv ***
// Eight-bit prescaled interval timer with classic Wishbone register access
// ------------------------------------------------------------
// Behaviour
// - Writing one to run_request starts counting, writing zero stops it.
// - count_active_flag is read-only, one while counting, zero when stopped; the code also reads one while the count is stalled.
// - Writing one to forced_halt stops the count at once; reads zero.
// - edge_seen_flag in run control, zero means no edge, write clears.
// - underflow_flag in run control, zero means no underflow, write clears.
// - operating_mode_field bits 2:0, code zero is plain timer mode.
// - Eight-bit prescaler counts the internal source, full 00h..FFh range.
// - priority_level_field selects request level, zero disables interrupt; the code only stores the level, and request_pending still sets at level zero.
// - request_pending at bit three shows a pending request, writable.
// ------------------------------------------------------------
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "pit_defines.svh"
module pit_top (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             COUNT_ACTIVE,
  output logic             UNDERFLOW_PULSE
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0] int_ctrl_q, int_ctrl_d;
  logic       run_req_q, run_req_d;
  logic       active_q, active_d;
  logic       edge_q, edge_d;
  logic       undf_q, undf_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] pin_q, pin_d;
  logic [7:0] pre_rld_q, pre_rld_d;
  logic [7:0] cnt_rld_q, cnt_rld_d;
  logic [7:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;
  logic       undf_pulse_q, undf_pulse_d;
  logic [31:0] rdat_q, rdat_d;
  logic        ack_q, ack_d;
  pit_pkg::pit_bus_state_t st_q, st_d;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic        src_ok;
  logic        pre_uf;
  logic        cnt_uf;
  // Write decode and stage borrows
  logic        halt_wr;
  logic        count_ok;
  logic [8:0]  pre_dec;
  logic [8:0]  cnt_dec;

  // Divider and core share the tick carrier; the core owns the enable
  pit_tick_if tk ();

  pit_div8 u_div (
    .clk (CLK),
    .rst (RST),
    .tk  (tk.src)
  );

  // Byte lane zero carries every register
  // Offsets compare whole, so no register answers at an alias
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // Decrement with underflow flag, used by both stages
  // The ninth bit is the borrow that marks a stage underflow
  function automatic logic [8:0] dec8(input logic [7:0] v);
    dec8 = {(v == 8'h00), v - 8'h01};
  endfunction

  // ------------------------------------------------------------
  // Count source selection
  // ------------------------------------------------------------
  // timer mode only
  // gate passes source
  // A wrong mode, source or a closed gate stalls both stages while the
  // status flag still reads one: the timer looks busy but never underflows
  always_comb begin
    src_ok = (mode_q[`PIT_MODE_LSB +: 3] == `PIT_MODE_TIMER)
          && (mode_q[`PIT_SRC_LSB +: 3] == `PIT_SRC_DIV8)
          && !mode_q[`PIT_GATE_BIT];
  end
  assign tk.enable = active_q && src_ok;

  // Writes act only on lane zero and only while the slave is idle
  assign wr_en = (st_q == pit_pkg::PIT_IDLE) && WB_CYC_I && WB_STB_I && WB_WE_I
              && WB_SEL_I[0];
  assign wbyte = WB_DAT_I[7:0];

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  // halt decoded early
  // The halt has to freeze both stages in the cycle it is written, so it
  // masks the tick path here instead of waiting for the status flop
  always_comb begin
    halt_wr  = wr_en && hit(WB_ADR_I, `PIT_OFS_RUN_CTRL) && wbyte[`PIT_HALT_BIT];
    count_ok = active_q && !halt_wr;
  end

  always_comb begin
    pre_dec = dec8(pre_q);
    cnt_dec = dec8(cnt_q);
    pre_uf  = tk.tick && count_ok && pre_dec[8];
    cnt_uf  = pre_uf && cnt_dec[8];
  end

  // ------------------------------------------------------------
  // Counter and flag next state
  // ------------------------------------------------------------
  // Reload values written while running take effect at the next underflow
  // only, so a period change never cuts the period in progress short
  // Bus write happens before hardware events so that a set wins over a clear
  always_comb begin
    int_ctrl_d   = int_ctrl_q;
    run_req_d    = run_req_q;
    edge_d       = edge_q;
    undf_d       = undf_q;
    mode_d       = mode_q;
    pin_d        = pin_q;
    pre_rld_d    = pre_rld_q;
    cnt_rld_d    = cnt_rld_q;
    pre_d        = pre_q;
    cnt_d        = cnt_q;
    undf_pulse_d = 1'b0;
    if (wr_en) begin
      if (hit(WB_ADR_I, `PIT_OFS_INT_CTRL)) begin
        int_ctrl_d = wbyte & `PIT_INT_RD_MASK;
      end else if (hit(WB_ADR_I, `PIT_OFS_RUN_CTRL)) begin
        run_req_d = wbyte[`PIT_RUN_REQ_BIT];
        edge_d    = wbyte[`PIT_EDGE_BIT] & edge_q;
        undf_d    = wbyte[`PIT_UNDF_BIT] & undf_q;
        if (wbyte[`PIT_HALT_BIT]) begin
          // Reload both stages so a later start runs a full period
          run_req_d = 1'b0;
          pre_d     = pre_rld_q;
          cnt_d     = cnt_rld_q;
        end
      end else if (hit(WB_ADR_I, `PIT_OFS_MODE_CFG)) begin
        mode_d = wbyte;
      end else if (hit(WB_ADR_I, `PIT_OFS_PIN_CTRL)) begin
        pin_d = wbyte;
      end else if (hit(WB_ADR_I, `PIT_OFS_PRESCALE)) begin
        pre_rld_d = wbyte;
        // Current value loads only while stopped; a running stage keeps counting
        if (!active_q) begin
          pre_d = wbyte;
        end
      end else if (hit(WB_ADR_I, `PIT_OFS_MAIN_CNT)) begin
        cnt_rld_d = wbyte;
        if (!active_q) begin
          cnt_d = wbyte;
        end
      end
    end
    if (tk.tick && count_ok) begin
      pre_d = pre_uf ? pre_rld_q : pre_dec[7:0];
      if (pre_uf) begin
        cnt_d = cnt_uf ? cnt_rld_q : cnt_dec[7:0];
      end
    end
    // The pulse mirrors the flag set so a monitor need not poll the bus
    // underflow sets flags and reloads
    if (cnt_uf) begin
      undf_d                  = 1'b1;
      int_ctrl_d[`PIT_IRQ_BIT] = 1'b1;
      undf_pulse_d            = 1'b1;
    end
  end

  // Status lags the request by a cycle, which is why software polls it;
  // a forced halt is the one case that drops it at once
  // status follows request one cycle later
  always_comb begin
    active_d = run_req_q && !halt_wr;
  end

  // Timer state registers only; every decision lives in the processes above
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      int_ctrl_q   <= `PIT_RST_BYTE;
      run_req_q    <= 1'b0;
      active_q     <= 1'b0;
      edge_q       <= 1'b0;
      undf_q       <= 1'b0;
      mode_q       <= `PIT_RST_BYTE;
      pin_q        <= `PIT_RST_BYTE;
      pre_rld_q    <= `PIT_RST_BYTE;
      cnt_rld_q    <= `PIT_RST_BYTE;
      pre_q        <= `PIT_RST_BYTE;
      cnt_q        <= `PIT_RST_BYTE;
      undf_pulse_q <= 1'b0;
    end else begin
      int_ctrl_q   <= int_ctrl_d;
      run_req_q    <= run_req_d;
      active_q     <= active_d;
      edge_q       <= edge_d;
      undf_q       <= undf_d;
      mode_q       <= mode_d;
      pin_q        <= pin_d;
      pre_rld_q    <= pre_rld_d;
      cnt_rld_q    <= cnt_rld_d;
      pre_q        <= pre_d;
      cnt_q        <= cnt_d;
      undf_pulse_q <= undf_pulse_d;
    end
  end

  // ------------------------------------------------------------
  // Wishbone slave: ack one cycle after the request, then one idle cycle
  // ------------------------------------------------------------
  // Reads sample the state at the taking edge, so a running count is one
  // cycle old when ack arrives; unmapped offsets read zero
  always_comb begin
    st_d   = st_q;
    ack_d  = 1'b0;
    rdat_d = rdat_q;
    case (st_q)
      pit_pkg::PIT_IDLE: begin
        if (WB_CYC_I && WB_STB_I) begin
          st_d   = pit_pkg::PIT_ACK;
          ack_d  = 1'b1;
          // Upper lanes always read zero
          rdat_d = 32'h0000_0000;
          if (hit(WB_ADR_I, `PIT_OFS_INT_CTRL)) begin
            rdat_d[7:0] = int_ctrl_q;
          end else if (hit(WB_ADR_I, `PIT_OFS_RUN_CTRL)) begin
            rdat_d[`PIT_RUN_REQ_BIT] = run_req_q;
            rdat_d[`PIT_ACTIVE_BIT]  = active_q;
            rdat_d[`PIT_EDGE_BIT]    = edge_q;
            rdat_d[`PIT_UNDF_BIT]    = undf_q;
          end else if (hit(WB_ADR_I, `PIT_OFS_MODE_CFG)) begin
            rdat_d[7:0] = mode_q;
          end else if (hit(WB_ADR_I, `PIT_OFS_PIN_CTRL)) begin
            rdat_d[7:0] = pin_q;
          end else if (hit(WB_ADR_I, `PIT_OFS_PRESCALE)) begin
            rdat_d[7:0] = pre_q;
          end else if (hit(WB_ADR_I, `PIT_OFS_MAIN_CNT)) begin
            rdat_d[7:0] = cnt_q;
          end
        end
      end
      default: begin
        // Ack lasts one cycle, then the slave is idle again
        st_d = pit_pkg::PIT_IDLE;
      end
    endcase
  end

  // Bus state registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q   <= pit_pkg::PIT_IDLE;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      st_q   <= st_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output comes straight from a flop, so no bus path is combinational
  assign WB_DAT_O        = rdat_q;
  assign WB_ACK_O        = ack_q;
  assign COUNT_ACTIVE    = active_q;
  assign UNDERFLOW_PULSE = undf_pulse_q;
endmodule

// *** core/pit_defines.svh ***
// Register offsets, field positions and reset values of the interval timer
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH
// ------------------------------------------------------------
// Register word addresses (one aligned word each)
// ------------------------------------------------------------
`define PIT_OFS_INT_CTRL   4'h0
`define PIT_OFS_RUN_CTRL   4'h1
`define PIT_OFS_MODE_CFG   4'h2
`define PIT_OFS_PIN_CTRL   4'h3
`define PIT_OFS_PRESCALE   4'h4
`define PIT_OFS_MAIN_CNT   4'h5
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PIT_RUN_REQ_BIT    0
`define PIT_ACTIVE_BIT     1
`define PIT_HALT_BIT       2
`define PIT_EDGE_BIT       4
`define PIT_UNDF_BIT       5
`define PIT_MODE_LSB       0
`define PIT_SRC_LSB        4
`define PIT_GATE_BIT       7
`define PIT_IRQ_BIT        3
`define PIT_LVL_LSB        0
// ------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------
`define PIT_MODE_TIMER     3'h0
`define PIT_SRC_DIV8       3'h1
`define PIT_DIV8_LAST      3'h7
`define PIT_RST_BYTE       8'h00
`define PIT_INT_RD_MASK    8'h0F
`define PIT_RUN_RD_MASK    8'h33
`endif

// *** core/pit_pkg.sv ***
// Types shared by the interval timer modules
package pit_pkg;
  typedef enum logic [1:0] {PIT_IDLE, PIT_ACK} pit_bus_state_t;
endpackage

// *** core/pit_tick_if.sv ***
// Carrier for the count source tick between the divider and the timer core
`timescale 1ns/1ps
interface pit_tick_if;
  logic tick;
  logic enable;
  modport src  (output tick, input enable);
  modport sink (input  tick, output enable);
endinterface

// *** core/pit_div8.sv ***
// Clock divided by eight, issued as a one-cycle enable pulse
`timescale 1ns/1ps
`include "pit_defines.svh"
module pit_div8 (
  input  wire logic clk,
  input  wire logic rst,
  pit_tick_if.src   tk
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       tick_q;
  logic       tick_d;

  // Count only while enabled so each run starts with a full source period
  always_comb begin
    cnt_d  = tk.enable ? cnt_q + 3'h1 : 3'h0;
    tick_d = tk.enable && (cnt_q == `PIT_DIV8_LAST);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;
endmodule

// *** tb/pit_chk.sv ***
// Concurrent checks on the interval timer top-level ports
`timescale 1ns/1ps
module pit_chk (
  input logic        CLK,
  input logic        RST,
  input logic        WB_CYC_I,
  input logic        WB_STB_I,
  input logic        WB_WE_I,
  input logic [3:0]  WB_ADR_I,
  input logic [3:0]  WB_SEL_I,
  input logic [31:0] WB_DAT_I,
  input logic [31:0] WB_DAT_O,
  input logic        WB_ACK_O,
  input logic        COUNT_ACTIVE,
  input logic        UNDERFLOW_PULSE
);
  // ------
  // Bus and count checks
  // ------
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic take;
  logic run_wr;
  // A request counts only while the slave is idle, so held requests are not retaken
  assign take   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign run_wr = take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == 4'h1;
  a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_due: assert property (take |=> WB_ACK_O)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(take))
    else $error("ack without a request");
  a_run_start: assert property (
    run_wr && WB_DAT_I[0] && !WB_DAT_I[2] |-> ##[1:3] COUNT_ACTIVE)
    else $error("count did not start");
  a_run_stop: assert property (run_wr && !WB_DAT_I[0] |-> ##[1:3] !COUNT_ACTIVE)
    else $error("count did not stop");
  a_halt_stop: assert property (run_wr && WB_DAT_I[2] |=> !COUNT_ACTIVE)
    else $error("forced halt ignored");
  a_halt_reads: assert property (
    take && !WB_WE_I && WB_ADR_I == 4'h1 |=> !WB_DAT_O[2] && WB_DAT_O[31:8] == 24'h0)
    else $error("halt bit or upper lanes read nonzero");
  a_unmapped_rd: assert property (take && !WB_WE_I && WB_ADR_I > 4'h5 |=> WB_DAT_O == 32'h0)
    else $error("unmapped read nonzero");
  a_unf_space: assert property (UNDERFLOW_PULSE |=> !UNDERFLOW_PULSE [*7])
    else $error("underflows closer than eight clocks");
  a_unf_active: assert property (UNDERFLOW_PULSE |-> $past(COUNT_ACTIVE))
    else $error("underflow while stopped");
endmodule
bind pit_top pit_chk pit_chk_inst (
  .CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
  .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .COUNT_ACTIVE, .UNDERFLOW_PULSE
);

// *** tb/testbench.sv ***
// Self-checking bench for the prescaled interval timer
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        active;
  logic        unf;
  logic [31:0] rv;
  int          mismatches;
  int          check_count;
  int          n;
  logic [3:0]  ta [5] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5};
  logic [7:0]  tw [5] = '{8'hFF, 8'hA5, 8'h5A, 8'hFF, 8'h80};
  logic [31:0] te [5] = '{32'h0F, 32'hA5, 32'h5A, 32'hFF, 32'h80};
  logic [7:0]  sm [3] = '{8'h11, 8'h20, 8'h90};
  pit_top pit_top_inst (
    .CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .COUNT_ACTIVE(active), .UNDERFLOW_PULSE(unf)
  );
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // ------
  // Shared tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; the request stands until ack is seen at an edge
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'h1 && k < 20);
    chk("bus ack", 32'(ack), 32'h1);
    rv = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic poll(input logic v);
    int k;
    k = 0;
    do begin
      bus(4'h1, 1'h0, 8'h00, 4'hF);
      k++;
    end while (rv[1] !== v && k < 10);
    chk("active flag", 32'(rv[1]), 32'(v));
    chk("active pin", 32'(active), 32'(v));
  endtask
  // Full setup order, then the spacing of two underflows
  task automatic period(input logic [7:0] p, input logic [7:0] c);
    int k;
    bus(4'h1, 1'h1, 8'h00, 4'hF);
    poll(1'h0);
    bus(4'h2, 1'h1, 8'h10, 4'hF);
    bus(4'h3, 1'h1, 8'h00, 4'hF);
    bus(4'h4, 1'h1, p, 4'hF);
    bus(4'h5, 1'h1, c, 4'hF);
    bus(4'h0, 1'h1, 8'h00, 4'hF);
    bus(4'h1, 1'h1, 8'h01, 4'hF);
    poll(1'h1);
    k = 0;
    while (unf !== 1'h1 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (unf !== 1'h1 && k < 9000);
    chk("period", 32'(k), 32'((p + 1) * (c + 1) * 8));
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog, well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    close_out();
  end
  // ------
  // Test sequence
  // ------
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h0;
    mismatches = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      bus(4'(i), 1'h0, 8'h00, 4'hF);
      chk("reset value", rv, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      bus(ta[i], 1'h1, tw[i], 4'hF);
      bus(ta[i], 1'h0, 8'h00, 4'hF);
      chk("readback", rv, te[i]);
    end
    // Lane zero off must leave the prescaler untouched
    bus(4'h4, 1'h1, 8'h11, 4'hE);
    bus(4'h4, 1'h0, 8'h00, 4'hF);
    chk("lane off write", rv, 32'hFF);
    bus(4'h6, 1'h1, 8'h5A, 4'hF);
    bus(4'h6, 1'h0, 8'h00, 4'hF);
    chk("unmapped", rv, 32'h0);
    period(8'h00, 8'h00);
    // Other mode, other source or gate closed: no underflow at all
    foreach (sm[i]) begin
      bus(4'h1, 1'h1, 8'h00, 4'hF);
      poll(1'h0);
      bus(4'h2, 1'h1, sm[i], 4'hF);
      bus(4'h1, 1'h1, 8'h01, 4'hF);
      n = 0;
      repeat (100) begin
        @(posedge clk);
        if (unf === 1'h1) n++;
      end
      chk("stalled pulses", 32'(n), 32'h0);
    end
    period(8'hFF, 8'h00);
    period(8'h18, 8'h18);
    period(8'h01, 8'h02);
    bus(4'h1, 1'h0, 8'h00, 4'hF);
    chk("run flags", rv, 32'h23);
    bus(4'h0, 1'h0, 8'h00, 4'hF);
    chk("request", rv, 32'h08);
    // Halt while running, keeping the underflow flag by writing it as one
    bus(4'h1, 1'h1, 8'h24, 4'hF);
    poll(1'h0);
    chk("halted", rv, 32'h20);
    // A stopped timer cannot set the flag again, so the clear is deterministic
    bus(4'h1, 1'h1, 8'h00, 4'hF);
    bus(4'h1, 1'h0, 8'h00, 4'hF);
    chk("flag cleared", rv, 32'h00);
    // Start from the reloaded stages, then halt together with a run request
    bus(4'h1, 1'h1, 8'h01, 4'hF);
    poll(1'h1);
    bus(4'h1, 1'h1, 8'h05, 4'hF);
    poll(1'h0);
    chk("halt wins", rv, 32'h0);
    close_out();
  end
endmodule
